//--- rf_link_status.sv
// Purpose: Read-only RF link status word with event interrupts over classic Wishbone
// Assumes: Front-end signals are on clk_i except the external field detector pin
// Notes: Registers at byte addresses 0x74 (status), 0x80 (irq status), 0x84 (irq mask)
`timescale 1ns/100ps
`include "rf_link_status_defs.svh"

module rf_link_status
  import rf_link_status_pkg::*;
#(
  parameter int FILTER_LEN = `FILTER_LEN,
  parameter logic [15:0] CHECK_RESIDUE = `CHECK_RESIDUE_DEFAULT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic [2:0] seq_state_i,
  input wire logic [3:0] power_gear_now_i,
  input wire logic field_on_i,
  input wire logic freq_valid_i,
  input wire logic loop_locked_i,
  input wire logic loop_ctrl_enable_i,
  input wire logic [15:0] check_accum_i,
  input wire logic check_inverted_i,
  input wire logic own_field_on_i,
  input wire logic external_field_pin_i,
  input wire logic active_mode_fault_event_i,
  input wire logic [2:0] active_mode_fault_code_i,
  input wire logic field_drive_request_i,
  input wire logic rx_ready_i,
  input wire logic tx_busy_i,
  input wire logic rx_busy_i,
  input wire logic [9:0] receive_gain_level_i
);

  // Refuse filter lengths the history register cannot hold
  if (FILTER_LEN < 2 || FILTER_LEN > 4) begin : g_bad_filter
    $error("FILTER_LEN must be 2 to 4");
  end

  state_s st_ff;
  state_s nxt_st;
  wb_req_s req;
  logic [31:0] status_word;
  logic [3:0] events;
  logic [3:0] wr_mask;
  logic wr_hit_stat;
  logic wr_hit_mask;

  // Bus request bundle
  assign req = '{adr: wb_adr_i, dat: wb_dat_i, sel: wb_sel_i, we: wb_we_i,
                 cyc: wb_cyc_i, stb: wb_stb_i};

  // Check result against zero or residue
  function automatic logic check_ok(input logic [15:0] acc, input logic inv,
                                    input logic [15:0] residue);
    check_ok = inv ? (acc == residue) : (acc == `CHECK_ZERO);
  endfunction : check_ok

  // Live status word assembly, pure read with no side effect
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`SEQ_STATE_LSB +: 3] = seq_state_i;
    status_word[`GEAR_LSB +: 4] = power_gear_now_i;
    status_word[`LOOP_ON_BIT] = loop_ctrl_enable_i & field_on_i & freq_valid_i
                                & loop_locked_i;
    status_word[`CHECK_OK_BIT] = check_ok(check_accum_i, check_inverted_i,
                                          CHECK_RESIDUE);
    status_word[`OWN_FIELD_BIT] = own_field_on_i;
    status_word[`EXT_FIELD_BIT] = st_ff.ext_filt;
    status_word[`FAULT_LSB +: 3] = st_ff.fault;
    status_word[`RX_READY_BIT] = rx_ready_i;
    status_word[`TX_BUSY_BIT] = tx_busy_i;
    status_word[`RX_BUSY_BIT] = rx_busy_i;
    status_word[`GAIN_LSB +: 10] = receive_gain_level_i;
  end

  // Events: fault, external field change, tx end, rx end
  assign events = {active_mode_fault_event_i,
                   st_ff.ext_filt ^ nxt_st.ext_filt,
                   st_ff.prev_busy_tx & ~tx_busy_i,
                   st_ff.prev_busy_rx & ~rx_busy_i};

  assign wr_hit_stat = req.cyc & req.stb & req.we & ~st_ff.ack & req.sel[0]
                       & (req.adr == `IRQ_STATUS_ADR);
  assign wr_hit_mask = req.cyc & req.stb & req.we & ~st_ff.ack & req.sel[0]
                       & (req.adr == `IRQ_MASK_ADR);
  assign wr_mask = wr_hit_stat ? req.dat[3:0] : 4'h0;

  // Next-state logic
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ext_sync = {st_ff.ext_sync[0], external_field_pin_i};
    nxt_st.ext_hist = {st_ff.ext_hist[2:0], st_ff.ext_sync[1]};
    // Filter: switch only after FILTER_LEN equal samples
    if (&st_ff.ext_hist[FILTER_LEN-1:0]) begin
      nxt_st.ext_filt = 1'b1;
    end else if (~|st_ff.ext_hist[FILTER_LEN-1:0]) begin
      nxt_st.ext_filt = 1'b0;
    end
    nxt_st.prev_busy_tx = tx_busy_i;
    nxt_st.prev_busy_rx = rx_busy_i;
    // Fault code: drive enable clears, a new event loads it
    if (active_mode_fault_event_i) begin
      nxt_st.fault = active_mode_fault_code_i;
    end else if (field_drive_request_i) begin
      nxt_st.fault = `FAULT_NONE;
    end
    // Sticky interrupts, set wins over write-one clear
    nxt_st.irq_status = (st_ff.irq_status & ~wr_mask) | events;
    if (wr_hit_mask) begin
      nxt_st.irq_mask = req.dat[3:0];
    end
    // Single-wait Wishbone slave, ack one cycle after request
    nxt_st.ack = req.cyc & req.stb & ~st_ff.ack;
    nxt_st.rdata = 32'h0000_0000;
    if (req.cyc & req.stb & ~req.we & ~st_ff.ack) begin
      case (req.adr)
        `RF_LINK_STATUS_ADR: nxt_st.rdata = status_word;
        `IRQ_STATUS_ADR: nxt_st.rdata = {28'h0000000, st_ff.irq_status};
        `IRQ_MASK_ADR: nxt_st.rdata = {28'h0000000, st_ff.irq_mask};
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register with synchronous reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '{ext_sync: 2'h0, ext_hist: 4'h0, ext_filt: 1'b0,
                 irq_status: `IRQ_RESET, irq_mask: `IRQ_RESET, fault: `FAULT_NONE,
                 rdata: 32'h0000_0000, ack: 1'b0, prev_busy_tx: 1'b0,
                 prev_busy_rx: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_dat_o = st_ff.rdata;
  assign wb_ack_o = st_ff.ack;
  assign irq_o = |(st_ff.irq_status & st_ff.irq_mask);

endmodule : rf_link_status

//--- rf_link_status_defs.svh
// Purpose: Offsets, field positions and reset values of the RF link status block
// Assumes: Word-addressed register indices, byte address is four times the index
// Notes: Definitions only
`ifndef RF_LINK_STATUS_DEFS_SVH
`define RF_LINK_STATUS_DEFS_SVH
`define RF_LINK_STATUS_IDX 8'h1D
`define IRQ_STATUS_IDX 8'h20
`define IRQ_MASK_IDX 8'h21
`define RF_LINK_STATUS_ADR 10'h074
`define IRQ_STATUS_ADR 10'h080
`define IRQ_MASK_ADR 10'h084
`define SEQ_STATE_LSB 24
`define GEAR_LSB 20
`define LOOP_ON_BIT 19
`define CHECK_OK_BIT 18
`define OWN_FIELD_BIT 17
`define EXT_FIELD_BIT 16
`define FAULT_LSB 13
`define RX_READY_BIT 12
`define TX_BUSY_BIT 11
`define RX_BUSY_BIT 10
`define GAIN_LSB 0
`define FILTER_LEN 4
`define IRQ_BITS 4
`define IRQ_RESET 4'h0
`define FAULT_NONE 3'h0
`define CHECK_ZERO 16'h0000
`define CHECK_RESIDUE_DEFAULT 16'h1D0F
`endif

//--- rf_link_status_pkg.sv
// Purpose: Types of the RF link status block
// Assumes: Constants live in rf_link_status_defs.svh
// Notes: Sequencer states, bus request and state register
package rf_link_status_pkg;
  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_WAIT_TX, SEQ_TX, SEQ_WAIT_RX, SEQ_WAIT_DATA, SEQ_RX, SEQ_LOOPBACK, SEQ_RSVD
  } seq_state_e;
  typedef struct packed {
    logic [9:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
    logic cyc;
    logic stb;
  } wb_req_s;
  typedef struct packed {
    logic [1:0] ext_sync;
    logic [3:0] ext_hist;
    logic ext_filt;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic [2:0] fault;
    logic [31:0] rdata;
    logic ack;
    logic prev_busy_tx;
    logic prev_busy_rx;
  } state_s;
endpackage : rf_link_status_pkg

//--- rf_link_status_monitor.sv
// Purpose: Port checker for rf_link_status
// Assumes: Status word at byte 0x74, ack one cycle after the taking edge
// Notes: Bound to every rf_link_status
`timescale 1ns/100ps
module rf_link_status_monitor #(
  parameter int FILTER_LEN = 4,
  parameter logic [15:0] CHECK_RESIDUE = 16'h1D0F
) (
  input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o,
  input wire logic [9:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic [2:0] seq_state_i,
  input wire logic [3:0] power_gear_now_i,
  input wire logic field_on_i, freq_valid_i, loop_locked_i, loop_ctrl_enable_i,
  input wire logic [15:0] check_accum_i,
  input wire logic check_inverted_i, own_field_on_i, rx_ready_i, tx_busy_i, rx_busy_i,
  input wire logic [9:0] receive_gain_level_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Status read taken at this edge
  wire rd = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i == 10'h074;
  property p_rsvd; wb_ack_o |-> wb_dat_o[31:27] == 5'h00; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_state; rd |=> wb_ack_o && wb_dat_o[26:24] == $past(seq_state_i); endproperty
  a_state: assert property (p_state) else $error("state field wrong");
  property p_gear; rd |=> wb_dat_o[23:20] == $past(power_gear_now_i); endproperty
  a_gear: assert property (p_gear) else $error("gear field wrong");
  property p_loop;
    rd |=> wb_dat_o[19] == ($past(field_on_i) && $past(freq_valid_i) && $past(loop_locked_i)
      && $past(loop_ctrl_enable_i));
  endproperty
  a_loop: assert property (p_loop) else $error("loop bit wrong");
  property p_check;
    rd |=> wb_dat_o[18] == ($past(check_inverted_i) ? $past(check_accum_i) == CHECK_RESIDUE
      : $past(check_accum_i) == 16'h0000);
  endproperty
  a_check: assert property (p_check) else $error("check bit wrong");
  property p_own; rd |=> wb_dat_o[17] == $past(own_field_on_i); endproperty
  a_own: assert property (p_own) else $error("own field bit wrong");
  property p_busy;
    rd |=> wb_dat_o[12:10] == {$past(rx_ready_i), $past(tx_busy_i), $past(rx_busy_i)};
  endproperty
  a_busy: assert property (p_busy) else $error("codec bits wrong");
  property p_gain; rd |=> wb_dat_o[9:0] == $past(receive_gain_level_i); endproperty
  a_gain: assert property (p_gain) else $error("gain field wrong");
endmodule : rf_link_status_monitor
bind rf_link_status rf_link_status_monitor #(.FILTER_LEN(FILTER_LEN), .CHECK_RESIDUE(CHECK_RESIDUE))
  i_mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_adr_i, .wb_dat_o, .seq_state_i,
  .power_gear_now_i, .field_on_i, .freq_valid_i, .loop_locked_i, .loop_ctrl_enable_i,
  .check_accum_i, .check_inverted_i, .own_field_on_i, .rx_ready_i, .tx_busy_i, .rx_busy_i,
  .receive_gain_level_i);

//--- rf_peer_model.sv
// Purpose: Peer that raises or drops its own RF field
// Assumes: Field follows the request one cycle late
// Notes: Behavioural
`timescale 1ns/100ps
module rf_peer_model (
  input wire logic clk_i,
  input wire logic field_req_i,
  output logic field_o
);
  // Field switches on the edge after the request
  always @(posedge clk_i) field_o <= field_req_i;
endmodule : rf_peer_model

//--- test_rf_link_status.sv
// Purpose: Self-checking bench for rf_link_status
// Assumes: Status 0x74, irq status 0x80, irq mask 0x84
// Notes: Live inputs come from an LFSR
`timescale 1ns/100ps
module test_rf_link_status;
  localparam logic [15:0] RES = 16'h1D0F;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, ev = 1'b0, fdr = 1'b0, req = 1'b0;
  logic irq, ack, pin;
  logic [9:0] adr = 10'h000;
  logic [31:0] wdat = 32'h0, rdat, q, r, seed = 32'h0008;
  logic [41:0] v = '0;
  logic [2:0] code = 3'h0;
  int err_count = 0, cmp_count = 0, ticks = 0;
  rf_link_status i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq_o(irq), .seq_state_i(v[2:0]), .power_gear_now_i(v[6:3]), .field_on_i(v[7]),
    .freq_valid_i(v[8]), .loop_locked_i(v[9]), .loop_ctrl_enable_i(v[10]),
    .check_accum_i(v[26:11]), .check_inverted_i(v[27]), .own_field_on_i(v[28]),
    .external_field_pin_i(pin), .active_mode_fault_event_i(ev), .active_mode_fault_code_i(code),
    .field_drive_request_i(fdr), .rx_ready_i(v[29]), .tx_busy_i(v[30]), .rx_busy_i(v[31]),
    .receive_gain_level_i(v[41:32]));
  rf_peer_model i_peer (.clk_i(clk_i), .field_req_i(req), .field_o(pin));
  // Clock and hang guard
  initial forever #20 clk_i = ~clk_i;
  always @(posedge clk_i) if (++ticks == 3000) begin
    err_count++;
    tally_and_finish();
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [31:0] model(input logic [41:0] x, input bit e, input int f);
    return {5'h00, x[2:0], x[6:3], &x[10:7], (x[27] ? x[26:11] == RES : x[26:11] == 16'h0),
      x[28], e, f[2:0], x[29], x[30], x[31], x[41:32]};
  endfunction : model
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask : chk
  // One classic cycle, data taken at the ack edge
  task automatic wb(input logic [9:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    adr <= a;
    we <= w;
    wdat <= d;
    cyc <= 1'b1;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
  endtask : wb
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(10'h074, 1'b0, 32'h0);
    chk("reset", q, model(v, 0, 0));
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      r = seed;
      seed = lfsr(seed);
      v <= {seed[9:0], r[31:27], (i % 3 == 0) ? 16'h0 : (i % 3 == 1) ? RES : r[26:11],
        i[2] ? 4'hF : r[10:7], r[6:0]};
      wb(10'h074, 1'b0, 32'h0);
      chk("status", q, model(v, 0, 0));
    end
    wb(10'h084, 1'b1, 32'h8);
    for (int c = 1; c < 5; c++) begin
      ev <= 1'b1;
      code <= c[2:0];
      @(posedge clk_i);
      ev <= 1'b0;
      wb(10'h074, 1'b0, 32'h0);
      chk("fault", {29'h0, q[15:13]}, c);
      chk("irq", {31'h0, irq}, 1);
      wb(10'h080, 1'b1, 32'hF);
      fdr <= 1'b1;
      @(posedge clk_i);
      fdr <= 1'b0;
      wb(10'h074, 1'b0, 32'h0);
      chk("fault clear", q, model(v, 0, 0));
    end
    req <= 1'b1;
    repeat (12) @(posedge clk_i);
    wb(10'h074, 1'b0, 32'h0);
    chk("ext field", q, model(v, 1, 0));
    wb(10'h3FC, 1'b0, 32'h0);
    chk("unmapped", q, 32'h0);
    tally_and_finish();
  end
endmodule : test_rf_link_status
